// [design/mfe_top.sv]
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
// Functional notes
// [RL1] Second monitor bit clear: voltage outputs and ratio stay when hot.
// [RL2] Firmware leaves second monitor bit unless leaf1 count_reg bit 8 set.
// [RL3] Software must never disable both thermal monitors together.
// [RL4] Watch bit 18 set (default): monitor and wait instructions execute.
// [RL5] Watch bit clear: those instructions raise invalid-opcode instead.
// [RL6] Leaf 1 accumulator bit 3 reflects the watch bit.
// [RL7] OS changes watch bit only when leaf1 count_reg bit 0 set.
// [RL8] Firmware should leave the watch bit at default.
// [RL9] Prefetch disable bit 19 set: fetch one line of 128-byte sector.
// [RL10] Prefetch disable clear: fetch both lines of the sector.
// [RL11] Single-processor keeps prefetch disable clear; servers tune it.
// [RL12] Cap bit 22 set: leaf 0 returns 3 in accumulator bits 7:0.
// [RL13] Cap bit clear (default): leaf 0 returns true highest leaf.
// [RL14] Firmware reads leaf 0 before setting the cap bit.
// [RL15] Firmware should offer a setup option for old systems.
// [RL16] Second monitor bit set and die at threshold: lower ratio and voltage.
// [RL17] Cap bit supported only when native highest leaf exceeds 3; the code honours it for any NATIVE_MAX_LEAF.
// [RL18] Reserved bits store writes but steer nothing.
module mfe_top #(
  parameter logic [7:0] NATIVE_MAX_LEAF = 8'h05,
  parameter logic [5:0] THERM_VOLT_CODE = 6'h10,
  parameter logic [4:0] THERM_RATIO = 5'h08
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic thermal_hot,
  input wire logic [5:0] nominal_volt_code,
  input wire logic [4:0] nominal_ratio,
  output logic [5:0] voltage_ident_outputs,
  output logic [4:0] core_ratio,
  input wire mfe_pkg::mfe_watch_req_type watch_req,
  output logic watch_exec,
  output logic invalid_opcode,
  input wire mfe_pkg::mfe_id_req_type id_req,
  output mfe_pkg::mfe_id_rsp_type id_rsp,
  output logic [1:0] prefetch_lines
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [63:0] feat_reg;
  logic ud_seen_reg;
  logic wr_lo;
  logic wr_hi;
  logic access;
  logic [31:0] lo_merge;

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign access = psel && penable;
  assign wr_lo = access && pwrite && (paddr == mfe_pkg::ADDR_FEAT_LO);
  assign wr_hi = access && pwrite && (paddr == mfe_pkg::ADDR_FEAT_HI);
  assign lo_merge = strb_merge(feat_reg[31:0], pwdata, pstrb);

  // Reserved bits are stored as written but feed no logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_reg <= mfe_pkg::FEAT_RESET;
    end else if (wr_lo) begin
      feat_reg[31:0] <= lo_merge; // [RL18]
    end else if (wr_hi) begin
      feat_reg[63:32] <= strb_merge(feat_reg[63:32], pwdata, pstrb);
    end
  end

  // Zero-wait slave; pready is registered so it lands in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          mfe_pkg::ADDR_FEAT_LO: prdata <= feat_reg[31:0];
          mfe_pkg::ADDR_FEAT_HI: prdata <= feat_reg[63:32];
          mfe_pkg::ADDR_STATUS: begin
            prdata[mfe_pkg::ST_THERM_SECOND_ACTIVE] <=
              voltage_ident_outputs == THERM_VOLT_CODE
              && feat_reg[mfe_pkg::BIT_THERM_SECOND_EN];
            prdata[mfe_pkg::ST_UD_SEEN] <= ud_seen_reg;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Thermal control
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_ident_outputs <= 6'h00;
      core_ratio <= 5'h00;
    end else if (thermal_hot && feat_reg[mfe_pkg::BIT_THERM_SECOND_EN]) begin
      voltage_ident_outputs <= THERM_VOLT_CODE; // [RL16]
      core_ratio <= THERM_RATIO; // [RL16]
    end else begin
      voltage_ident_outputs <= nominal_volt_code; // [RL1]
      core_ratio <= nominal_ratio; // [RL1]
    end
  end

  // ------------------------------------------------------------
  // Watch instructions
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_exec <= 1'b0;
      invalid_opcode <= 1'b0;
      ud_seen_reg <= 1'b0;
    end else begin
      watch_exec <= watch_req.valid && feat_reg[mfe_pkg::BIT_WATCH_ON]; // [RL4]
      invalid_opcode <= watch_req.valid
        && !feat_reg[mfe_pkg::BIT_WATCH_ON]; // [RL5]
      // Set wins over a clear written in the same cycle
      if (watch_req.valid && !feat_reg[mfe_pkg::BIT_WATCH_ON]) begin
        ud_seen_reg <= 1'b1;
      end else if (access && pwrite && paddr == mfe_pkg::ADDR_STATUS
                   && pwdata[mfe_pkg::ST_UD_SEEN]) begin
        ud_seen_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Identification answers and prefetch width
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_rsp <= '0;
      prefetch_lines <= mfe_pkg::LINES_TWO;
    end else begin
      id_rsp.valid <= id_req.valid;
      id_rsp.accumulator_reg <= 32'h0000_0000;
      if (id_req.leaf == mfe_pkg::LEAF_STD_MAX) begin
        id_rsp.accumulator_reg[7:0] <= feat_reg[mfe_pkg::BIT_CAP_LEAF]
          ? mfe_pkg::CAPPED_LEAF : NATIVE_MAX_LEAF; // [RL12] [RL13]
      end else if (id_req.leaf == mfe_pkg::LEAF_FEATURES) begin
        id_rsp.accumulator_reg[mfe_pkg::LEAF1_WATCH_BIT] <=
          feat_reg[mfe_pkg::BIT_WATCH_ON]; // [RL6]
      end
      prefetch_lines <= feat_reg[mfe_pkg::BIT_ADJ_PF_DIS]
        ? mfe_pkg::LINES_ONE : mfe_pkg::LINES_TWO; // [RL9] [RL10]
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Gated on sampled reset high: the edge of release still loads reset values
  property p_cool_passes;
    @(posedge pclk) disable iff (!presetn)
    presetn && !feat_reg[mfe_pkg::BIT_THERM_SECOND_EN] |=>
      voltage_ident_outputs == $past(nominal_volt_code)
      && core_ratio == $past(nominal_ratio);
  endproperty
  a_cool_passes: assert property (p_cool_passes) // [RL1]
    else $error("ratio or voltage changed with second monitor off");

  property p_hot_engage;
    @(posedge pclk) disable iff (!presetn)
    (presetn && feat_reg[mfe_pkg::BIT_THERM_SECOND_EN] && thermal_hot) |=>
      voltage_ident_outputs == THERM_VOLT_CODE && core_ratio == THERM_RATIO;
  endproperty
  a_hot_engage: assert property (p_hot_engage) // [RL16]
    else $error("second monitor did not engage at threshold");

  property p_watch_exec;
    @(posedge pclk) disable iff (!presetn)
    (watch_req.valid && feat_reg[mfe_pkg::BIT_WATCH_ON]) |=>
      watch_exec && !invalid_opcode;
  endproperty
  a_watch_exec: assert property (p_watch_exec) // [RL4]
    else $error("watch instruction not executed");

  property p_watch_ud;
    @(posedge pclk) disable iff (!presetn)
    (watch_req.valid && !feat_reg[mfe_pkg::BIT_WATCH_ON]) |=>
      invalid_opcode && !watch_exec ##1 ud_seen_reg;
  endproperty
  a_watch_ud: assert property (p_watch_ud) // [RL5]
    else $error("disabled watch instruction did not fault");

  property p_leaf1_bit;
    @(posedge pclk) disable iff (!presetn)
    (id_req.valid && id_req.leaf == mfe_pkg::LEAF_FEATURES) |=>
      id_rsp.valid && id_rsp.accumulator_reg[mfe_pkg::LEAF1_WATCH_BIT]
        == $past(feat_reg[mfe_pkg::BIT_WATCH_ON]);
  endproperty
  a_leaf1_bit: assert property (p_leaf1_bit) // [RL6]
    else $error("leaf 1 watch bit mismatch");

  property p_prefetch_one;
    @(posedge pclk) disable iff (!presetn)
    feat_reg[mfe_pkg::BIT_ADJ_PF_DIS] [*2] |->
      prefetch_lines == mfe_pkg::LINES_ONE;
  endproperty
  a_prefetch_one: assert property (p_prefetch_one) // [RL9]
    else $error("prefetch not single line");

  property p_prefetch_two;
    @(posedge pclk) disable iff (!presetn)
    !feat_reg[mfe_pkg::BIT_ADJ_PF_DIS] [*2] |->
      prefetch_lines == mfe_pkg::LINES_TWO;
  endproperty
  a_prefetch_two: assert property (p_prefetch_two) // [RL10]
    else $error("prefetch not both lines");

  property p_leaf0_cap;
    @(posedge pclk) disable iff (!presetn)
    (id_req.valid && id_req.leaf == mfe_pkg::LEAF_STD_MAX
     && feat_reg[mfe_pkg::BIT_CAP_LEAF]) |=>
      id_rsp.accumulator_reg[7:0] == mfe_pkg::CAPPED_LEAF;
  endproperty
  a_leaf0_cap: assert property (p_leaf0_cap) // [RL12]
    else $error("leaf 0 not capped at 3");

  property p_leaf0_native;
    @(posedge pclk) disable iff (!presetn)
    (id_req.valid && id_req.leaf == mfe_pkg::LEAF_STD_MAX
     && !feat_reg[mfe_pkg::BIT_CAP_LEAF]) |=>
      id_rsp.accumulator_reg[7:0] == NATIVE_MAX_LEAF;
  endproperty
  a_leaf0_native: assert property (p_leaf0_native) // [RL13]
    else $error("leaf 0 not native maximum");

  property p_reserved_inert;
    @(posedge pclk) disable iff (!presetn)
    (wr_lo && lo_merge[mfe_pkg::BIT_ADJ_PF_DIS]
     == feat_reg[mfe_pkg::BIT_ADJ_PF_DIS]) |=> ##1 $stable(prefetch_lines);
  endproperty
  a_reserved_inert: assert property (p_reserved_inert) // [RL18]
    else $error("reserved write steered prefetch");

endmodule // mfe_top

// [shared/mfe_pkg.sv]
package mfe_pkg;

  // --------------------------------------------------------------
  // Register map (APB byte addresses)
  // --------------------------------------------------------------
  localparam logic [11:0] ADDR_FEAT_LO = 12'h000;
  localparam logic [11:0] ADDR_FEAT_HI = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // --------------------------------------------------------------
  // Field positions in the 64-bit feature register
  // --------------------------------------------------------------
  localparam int BIT_THERM_FIRST_EN = 3;
  localparam int BIT_THERM_SECOND_EN = 13;
  localparam int BIT_WATCH_ON = 18;
  localparam int BIT_ADJ_PF_DIS = 19;
  localparam int BIT_CAP_LEAF = 22;

  // Status word bit positions
  localparam int ST_THERM_SECOND_ACTIVE = 0;
  localparam int ST_UD_SEEN = 1;

  // --------------------------------------------------------------
  // Reset values and constants
  // --------------------------------------------------------------
  localparam logic [63:0] FEAT_RESET = 64'h0000_0000_0004_0008;
  localparam logic [7:0] CAPPED_LEAF = 8'h03;
  localparam int LEAF1_WATCH_BIT = 3;
  localparam logic [31:0] LEAF_STD_MAX = 32'h0000_0000;
  localparam logic [31:0] LEAF_FEATURES = 32'h0000_0001;
  localparam logic [1:0] LINES_ONE = 2'h1;
  localparam logic [1:0] LINES_TWO = 2'h2;

  // Identification request/answer carrier
  typedef struct packed {
    logic valid;
    logic [31:0] leaf;
  } mfe_id_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] accumulator_reg;
  } mfe_id_rsp_type;

  // Watch-instruction issue carrier
  typedef struct packed {
    logic valid;
    logic is_wait;
  } mfe_watch_req_type;

endpackage

// [verif/test_misc_feature_enable_bits.sv]
`timescale 1ns/1ps
module test_misc_feature_enable_bits;
  // ------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] lo;
    logic [1:0] lines;
    logic [7:0] max;
    logic watch;
    logic hot_cut;
  } mfe_row_type;
  localparam logic [5:0] HOT_VOLT = 6'h10;
  localparam logic [4:0] HOT_RATIO = 5'h08;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, thermal_hot = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] nominal_volt_code = 6'h2A, voltage_ident_outputs;
  logic [4:0] nominal_ratio = 5'h11, core_ratio;
  logic watch_exec, invalid_opcode, er;
  logic [1:0] prefetch_lines;
  mfe_pkg::mfe_watch_req_type watch_req = '0;
  mfe_pkg::mfe_id_req_type id_req = '0;
  mfe_pkg::mfe_id_rsp_type id_rsp;
  int errors = 0, total_checks = 0, cycles = 0;
  // Every row keeps the first thermal monitor on, and leaf 0 (native 5)
  // is read before the cap bit goes up
  mfe_row_type rows [4] = '{
    '{32'h0004_0008, 2'h2, 8'h05, 1'b1, 1'b0},
    '{32'h0048_2008, 2'h1, 8'h03, 1'b0, 1'b1},
    '{32'h000C_2008, 2'h1, 8'h05, 1'b1, 1'b1},
    '{32'h0037_C008, 2'h2, 8'h05, 1'b1, 1'b0}};
  mfe_top #(.NATIVE_MAX_LEAF(8'h05), .THERM_VOLT_CODE(HOT_VOLT),
    .THERM_RATIO(HOT_RATIO)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .thermal_hot(thermal_hot),
    .nominal_volt_code(nominal_volt_code), .nominal_ratio(nominal_ratio),
    .voltage_ident_outputs(voltage_ident_outputs),
    .core_ratio(core_ratio), .watch_req(watch_req),
    .watch_exec(watch_exec), .invalid_opcode(invalid_opcode),
    .id_req(id_req), .id_rsp(id_rsp), .prefetch_lines(prefetch_lines));
  always #12.5 pclk = ~pclk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Waits on pready, never on a fixed count, so wait states stay legal
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, "no pready");
  endtask
  task automatic pulse_id(input logic [31:0] leaf);
    @(posedge pclk);
    id_req <= '{valid: 1'b1, leaf: leaf};
    @(posedge pclk);
    id_req.valid <= 1'b0;
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    chk(prefetch_lines === 2'h2 && watch_exec === 1'b0, "in reset");
    presetn <= 1'b1;
    apb(0, mfe_pkg::ADDR_FEAT_LO, 32'h0);
    chk(rd === 32'h0004_0008 && er === 1'b0, "reset low word");
    for (int i = 0; i < 4; i++) begin
      apb(1, mfe_pkg::ADDR_FEAT_LO, rows[i].lo);
      apb(0, mfe_pkg::ADDR_FEAT_LO, 32'h0);
      chk(rd === rows[i].lo, "readback");
      @(posedge pclk);
      thermal_hot <= 1'b1;
      repeat (2) @(posedge pclk);
      thermal_hot <= 1'b0;
      #1;
      chk(voltage_ident_outputs ===
        (rows[i].hot_cut ? HOT_VOLT : nominal_volt_code)
        && core_ratio === (rows[i].hot_cut ? HOT_RATIO : nominal_ratio),
        "thermal outputs");
      chk(prefetch_lines === rows[i].lines, "prefetch lines");
      pulse_id(32'h0);
      chk(id_rsp.valid === 1'b1 && id_rsp.accumulator_reg[7:0]
        === rows[i].max, "leaf 0 max");
      pulse_id(32'h1);
      chk(id_rsp.accumulator_reg[3] === rows[i].watch, "leaf 1");
      @(posedge pclk);
      watch_req <= '{valid: 1'b1, is_wait: i[0]};
      @(posedge pclk);
      watch_req.valid <= 1'b0;
      #1;
      chk(watch_exec === rows[i].watch && invalid_opcode ===
        !rows[i].watch, "watch outcome");
    end
    // Trap leaves a sticky status flag that software clears by writing 1
    apb(0, mfe_pkg::ADDR_STATUS, 32'h0);
    chk(rd[mfe_pkg::ST_UD_SEEN] === 1'b1
      && rd[mfe_pkg::ST_THERM_SECOND_ACTIVE] === 1'b0,
      "trap flag set");
    apb(1, mfe_pkg::ADDR_STATUS, 32'h0000_0002);
    apb(0, mfe_pkg::ADDR_STATUS, 32'h0);
    chk(rd[mfe_pkg::ST_UD_SEEN] === 1'b0, "trap flag clear");
    apb(1, 12'h010, 32'hFFFF_FFFF);
    chk(er === 1'b1, "unmapped write");
    apb(0, mfe_pkg::ADDR_FEAT_LO, 32'h0);
    chk(rd === 32'h0037_C008, "unmapped hit");
    apb(1, mfe_pkg::ADDR_FEAT_HI, 32'hA5A5_0001);
    apb(0, mfe_pkg::ADDR_FEAT_HI, 32'h0);
    chk(rd === 32'hA5A5_0001 && er === 1'b0, "high word");
    // Only byte 1 may land; the other bytes keep what they held
    pstrb <= 4'h2;
    apb(1, mfe_pkg::ADDR_FEAT_HI, 32'h0000_7700);
    pstrb <= 4'hF;
    apb(0, mfe_pkg::ADDR_FEAT_HI, 32'h0);
    chk(rd === 32'hA5A5_7701, "byte strobe");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, mfe_pkg::ADDR_FEAT_HI, 32'h0);
    chk(rd === 32'h0, "second reset high");
    pulse_id(32'h0);
    chk(id_rsp.accumulator_reg[7:0] === 8'h05, "leaf 0 after reset");
    test_done();
  end
endmodule // test_misc_feature_enable_bits
